// ---- pkg/pixel_gain_pkg.sv ----
// constants and types shared by the pixel gain, table and settings store logic
package pixel_gain_pkg;
    localparam int PIX_W = 12;
    localparam int LUT_DEPTH = 1 << PIX_W;
    localparam int GAIN_W = 9;
    localparam int FACT_W = 22;
    localparam int FACT_FRAC = 16;
    localparam int RATIO_W = 12;
    localparam int RATIO_FRAC = 8;
    localparam int PED_W = 10;
    localparam int PED_SHIFT = 2;
    localparam int SLOTS = 16;
    localparam int ADDR_W = 8;
    localparam int GAIN_DB_DIV = 20;
    // register byte offsets
    localparam logic [7:0] OFS_AMPLIFICATION = 8'h00;
    localparam logic [7:0] OFS_PEDESTAL_OFFSET = 8'h04;
    localparam logic [7:0] OFS_COLOR_SELECT = 8'h08;
    localparam logic [7:0] OFS_COLOR_MULT = 8'h0C;
    localparam logic [7:0] OFS_AUTO_WB = 8'h10;
    localparam logic [7:0] OFS_TABLE_ENABLE = 8'h14;
    localparam logic [7:0] OFS_TABLE_INPUT = 8'h18;
    localparam logic [7:0] OFS_TABLE_OUTPUT = 8'h1C;
    localparam logic [7:0] OFS_SLOT_SELECT = 8'h20;
    localparam logic [7:0] OFS_RESTORE_CMD = 8'h24;
    localparam logic [7:0] OFS_PERSIST_CMD = 8'h28;
    localparam logic [7:0] OFS_VOLATILE_CMD = 8'h2C;
    localparam logic [7:0] OFS_POWER_UP_SLOT = 8'h30;
    localparam logic [7:0] OFS_PIXEL_ENCODING = 8'h34;
    localparam logic [7:0] OFS_OTHER_PARAMS = 8'h38;
    localparam logic [7:0] OFS_SEQUENCE_ENABLE = 8'h3C;
    localparam logic [7:0] OFS_STATUS = 8'h40;
    // limits and reset values
    localparam logic [8:0] AMP_MAX = 9'h168;
    localparam logic [8:0] AMP_RESET = 9'h000;
    localparam logic signed [9:0] PED_MAX = 10'sh100;
    localparam logic signed [9:0] PED_MIN = -10'sh100;
    localparam logic [9:0] PED_RESET = 10'h000;
    localparam logic [11:0] RATIO_ONE = 12'h100;
    localparam logic [11:0] RATIO_MAX = 12'h800;
    localparam logic [21:0] FACT_ONE = 22'h01_0000;
    localparam logic [3:0] SLOT_DEFAULT = 4'h0;
    localparam logic [1:0] ENC_RESET = 2'h0;
    localparam logic [1:0] ENC_MOSAIC8 = 2'h1;
    // factor for each set bit of the gain code, 10^(2^i/200), 16 fraction bits
    localparam logic [21:0] GAIN_STEP [GAIN_W] = '{22'h01_02F7, 22'h01_05F6, 22'h01_0C10,
        22'h01_18B2, 22'h01_33C8, 22'h01_7208, 22'h02_16DC, 22'h04_5D7B, 22'h13_0DFA};
    typedef enum logic [1:0] {CH_NONE = 2'h0, CH_RED = 2'h1, CH_BLUE = 2'h2} chan_sel_e;
    typedef enum logic {AWB_OFF = 1'b0, AWB_ONCE = 1'b1} awb_mode_e;
    typedef enum logic [1:0] {PH_GREEN = 2'h0, PH_RED = 2'h1, PH_BLUE = 2'h2} pix_phase_e;
    typedef struct packed {
        logic valid;
        logic sof;
        logic [1:0] phase;
        logic [11:0] value;
    } pixel_s;
    typedef struct packed {
        logic done;
        logic ok;
        logic [11:0] red;
        logic [11:0] blue;
    } awb_result_s;
    typedef struct packed {
        logic [8:0] amp;
        logic [9:0] ped;
        logic [11:0] red;
        logic [11:0] blue;
        logic lut_en;
        logic [1:0] enc;
        logic [31:0] other;
    } param_set_s;
    localparam param_set_s FACTORY_SET = '{amp: AMP_RESET, ped: PED_RESET, red: RATIO_ONE,
        blue: RATIO_ONE, lut_en: 1'b0, enc: ENC_RESET, other: 32'h0000_0000};
endpackage : pixel_gain_pkg

// ---- hw/gain_factor_calc.sv ----
// serial converter from a gain code in tenths of a decibel to a linear factor
`timescale 1ns/1ps
`default_nettype none
module gain_factor_calc (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [pixel_gain_pkg::GAIN_W-1:0] code,
    output logic busy,
    output logic [pixel_gain_pkg::FACT_W-1:0] factor
);
    import pixel_gain_pkg::*;

    localparam logic [3:0] LAST_BIT = 4'(GAIN_W - 1);
    logic [GAIN_W-1:0] code_ff;
    logic [3:0] bit_ff;
    logic [FACT_W-1:0] acc_ff;
    logic [FACT_W-1:0] factor_ff;
    logic busy_ff;
    logic [2*FACT_W-1:0] prod;
    logic [FACT_W-1:0] nxt_acc;

    // one code bit per cycle, multiplying in its power of ten
    assign prod = acc_ff * GAIN_STEP[bit_ff];
    assign nxt_acc = code_ff[bit_ff] ? prod[FACT_FRAC +: FACT_W] : acc_ff;

    // walk the code bits, publish the factor when the last one is done
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            code_ff <= AMP_RESET;
            bit_ff <= 4'h0;
            acc_ff <= FACT_ONE;
            factor_ff <= FACT_ONE;
            busy_ff <= 1'b0;
        end else if (start) begin
            code_ff <= code;
            bit_ff <= 4'h0;
            acc_ff <= FACT_ONE;
            busy_ff <= 1'b1;
        end else if (busy_ff) begin
            acc_ff <= nxt_acc;
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == LAST_BIT) begin
                busy_ff <= 1'b0;
                factor_ff <= nxt_acc;
            end
        end
    end

    assign busy = busy_ff;
    assign factor = factor_ff;
endmodule : gain_factor_calc
`default_nettype wire

// ---- hw/pixel_gain_lut_settings_store.sv ----
// pixel gain, pedestal, white balance and table stage with its parameter set store
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - each pixel is multiplied by ten to the power gain in dB over 20
// - amplification takes codes 0 to 360 in tenths of a dB, resets to 0
// - pedestal takes signed codes -256 to 256, resets to 0, 100/1024 percent each
// - pedestal is added to pixels over minus to plus 25 percent of white
// - channel select offers none, red, blue; resets to none, none addresses nothing
// - multiplier write updates only the selected red or blue gain, range 1 to 8
// - multiplier and auto balance work only in 8-bit mosaic encoding on colour builds
// - auto balance once runs one pass, success loads red and blue; off ends a running pass
// - each 12-bit pixel maps through a programmable table to a 12-bit value
// - software writes table input then output; output stored at that input, 0 to 4095
// - table applies only while its enable is set, otherwise values pass unmapped
// - fifteen user slots exist beside the factory default set
// - persist command copies current parameters into the selected non-volatile slot
// - quick-store command copies current parameters into the selected volatile slot only
// - restore command loads the selected slot and makes it the active configuration
// - after power-up the set in the power-up slot register is loaded
// - saved sets hold gain, pedestal, multipliers, table enable and the other parameters
// - shared parameters keep one value; sequence enable is common to user slots only
module pixel_gain_lut_settings_store #(
    parameter bit COLOR_MODEL = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic nv_init,
    input wire logic [pixel_gain_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire pixel_gain_pkg::pixel_s pix_in,
    output var pixel_gain_pkg::pixel_s pix_out,
    output logic awb_start,
    input wire pixel_gain_pkg::awb_result_s awb_res
);
    import pixel_gain_pkg::*;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_IDLE = 3'b010,
        ST_AWB = 3'b100
    } state_e;

    state_e state_ff;
    state_e nxt_state;
    logic [GAIN_W-1:0] amp_ff;
    logic [PED_W-1:0] ped_ff;
    logic [RATIO_W-1:0] red_ff;
    logic [RATIO_W-1:0] blue_ff;
    logic lut_en_ff;
    logic [1:0] enc_ff;
    logic [31:0] other_ff;
    logic seq_en_ff;
    logic seq_user_ff;
    chan_sel_e sel_ff;
    logic [PIX_W-1:0] lut_idx_ff;
    logic [3:0] slot_sel_ff;
    logic [3:0] pwr_slot_ff;
    logic [PIX_W-1:0] lut_ff [LUT_DEPTH];
    param_set_s vol_ff [SLOTS];
    param_set_s nv_ff [SLOTS];
    logic awb_start_ff;
    logic [31:0] rdata_ff;
    pixel_s s1_ff;
    pixel_s s2_ff;
    pixel_s s3_ff;
    pixel_s out_ff;
    logic [GAIN_W-1:0] launched_ff;
    logic [FACT_W-1:0] factor;
    logic gain_busy;
    param_set_s cur_set;
    param_set_s slot_set;
    param_set_s boot_set;
    logic color_ok;
    logic save_ok;
    logic awb_go;
    logic awb_stop;
    logic awb_hit;

    // write strobe aimed at one register offset
    function automatic logic wr_at(input logic [ADDR_W-1:0] ofs);
        return reg_wr && (reg_addr == ofs);
    endfunction : wr_at

    // saturate an unsigned intermediate to the pixel range
    function automatic logic [PIX_W-1:0] clamp_pix(input logic [33:0] v);
        return (|v[33:PIX_W]) ? {PIX_W{1'b1}} : v[PIX_W-1:0];
    endfunction : clamp_pix

    // saturate a signed intermediate to the pixel range
    function automatic logic [PIX_W-1:0] clamp_signed(input logic signed [14:0] v);
        logic [PIX_W-1:0] r;
        r = v[PIX_W-1:0];
        if (v < 0) begin
            r = '0;
        end else if (|v[14:PIX_W]) begin
            r = {PIX_W{1'b1}};
        end
        return r;
    endfunction : clamp_signed

    // hold a white balance gain inside one to eight times
    function automatic logic [RATIO_W-1:0] clamp_ratio(input logic [31:0] v);
        logic [RATIO_W-1:0] r;
        r = v[RATIO_W-1:0];
        if (v < 32'(RATIO_ONE)) begin
            r = RATIO_ONE;
        end else if (v > 32'(RATIO_MAX)) begin
            r = RATIO_MAX;
        end
        return r;
    endfunction : clamp_ratio

    // qualifiers for balance and slot commands
    assign color_ok = COLOR_MODEL && (enc_ff == ENC_MOSAIC8);
    assign save_ok = (slot_sel_ff != SLOT_DEFAULT);
    assign awb_hit = reg_wr && (reg_addr == OFS_AUTO_WB);
    assign awb_go = awb_hit && (reg_wdata[0] == AWB_ONCE) && color_ok;
    assign awb_stop = awb_hit && (reg_wdata[0] == AWB_OFF);

    // current set and the sets that restore and boot pick up
    assign cur_set = '{amp: amp_ff, ped: ped_ff, red: red_ff, blue: blue_ff,
        lut_en: lut_en_ff, enc: enc_ff, other: other_ff};
    assign slot_set = save_ok ? vol_ff[slot_sel_ff] : FACTORY_SET;
    assign boot_set = (pwr_slot_ff == SLOT_DEFAULT) ? FACTORY_SET : nv_ff[pwr_slot_ff];

    // control sequence: boot load, idle, one balance pass
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_BOOT: begin
                nxt_state = ST_IDLE;
            end
            ST_IDLE: begin
                if (awb_go) begin
                    nxt_state = ST_AWB;
                end
            end
            ST_AWB: begin
                if (awb_res.done || awb_stop) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_BOOT;
            end
        endcase
    end

    // state register and balance start pulse
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= ST_BOOT;
            awb_start_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            awb_start_ff <= (state_ff == ST_IDLE) && awb_go;
        end
    end

    // active parameter set: boot, restore, balance result, then register writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {amp_ff, ped_ff, red_ff, blue_ff, lut_en_ff, enc_ff, other_ff} <= FACTORY_SET;
            seq_en_ff <= 1'b0;
        end else if (state_ff == ST_BOOT) begin
            {amp_ff, ped_ff, red_ff, blue_ff, lut_en_ff, enc_ff, other_ff} <= boot_set;
            seq_en_ff <= (pwr_slot_ff == SLOT_DEFAULT) ? 1'b0 : seq_user_ff;
        end else if (wr_at(OFS_RESTORE_CMD)) begin
            {amp_ff, ped_ff, red_ff, blue_ff, lut_en_ff, enc_ff, other_ff} <= slot_set;
            seq_en_ff <= save_ok ? seq_user_ff : 1'b0;
        end else begin
            if (wr_at(OFS_AMPLIFICATION)) begin
                amp_ff <= (reg_wdata > 32'(AMP_MAX)) ? AMP_MAX : reg_wdata[GAIN_W-1:0];
            end
            if (wr_at(OFS_PEDESTAL_OFFSET)) begin
                if ($signed(reg_wdata) > PED_MAX) begin
                    ped_ff <= PED_MAX;
                end else if ($signed(reg_wdata) < PED_MIN) begin
                    ped_ff <= PED_MIN;
                end else begin
                    ped_ff <= reg_wdata[PED_W-1:0];
                end
            end
            if ((state_ff == ST_AWB) && awb_res.done && awb_res.ok) begin
                red_ff <= clamp_ratio({20'h0_0000, awb_res.red});
                blue_ff <= clamp_ratio({20'h0_0000, awb_res.blue});
            end else if (wr_at(OFS_COLOR_MULT) && color_ok) begin
                case (sel_ff)
                    CH_RED: begin
                        red_ff <= clamp_ratio(reg_wdata);
                    end
                    CH_BLUE: begin
                        blue_ff <= clamp_ratio(reg_wdata);
                    end
                    default: begin
                        red_ff <= red_ff;
                    end
                endcase
            end
            if (wr_at(OFS_TABLE_ENABLE)) begin
                lut_en_ff <= reg_wdata[0];
            end
            if (wr_at(OFS_PIXEL_ENCODING)) begin
                enc_ff <= reg_wdata[1:0];
            end
            if (wr_at(OFS_OTHER_PARAMS)) begin
                other_ff <= reg_wdata;
            end
            if (wr_at(OFS_SEQUENCE_ENABLE)) begin
                seq_en_ff <= reg_wdata[0];
            end
        end
    end

    // selectors that are not part of a stored set
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_ff <= CH_NONE;
            lut_idx_ff <= '0;
            slot_sel_ff <= SLOT_DEFAULT;
        end else begin
            if (wr_at(OFS_COLOR_SELECT) && (reg_wdata <= 32'(CH_BLUE))) begin
                sel_ff <= chan_sel_e'(reg_wdata[1:0]);
            end
            if (wr_at(OFS_TABLE_INPUT)) begin
                lut_idx_ff <= reg_wdata[PIX_W-1:0];
            end
            if (wr_at(OFS_SLOT_SELECT) && (reg_wdata < SLOTS)) begin
                slot_sel_ff <= reg_wdata[3:0];
            end
        end
    end

    // non-volatile slots, shared sequence enable and power-up choice
    always_ff @(posedge sys_clk) begin
        if (nv_init) begin
            for (int i = 0; i < SLOTS; i++) begin
                nv_ff[i] <= FACTORY_SET;
            end
            seq_user_ff <= 1'b0;
            pwr_slot_ff <= SLOT_DEFAULT;
        end else begin
            if (wr_at(OFS_PERSIST_CMD) && save_ok) begin
                nv_ff[slot_sel_ff] <= cur_set;
            end
            if ((wr_at(OFS_PERSIST_CMD) || wr_at(OFS_VOLATILE_CMD)) && save_ok) begin
                seq_user_ff <= seq_en_ff;
            end
            if (wr_at(OFS_POWER_UP_SLOT) && (reg_wdata < SLOTS)) begin
                pwr_slot_ff <= reg_wdata[3:0];
            end
        end
    end

    // volatile slots, refilled from the non-volatile copy at boot
    always_ff @(posedge sys_clk) begin
        if (state_ff == ST_BOOT) begin
            for (int i = 0; i < SLOTS; i++) begin
                vol_ff[i] <= nv_ff[i];
            end
        end else if (save_ok && (wr_at(OFS_PERSIST_CMD) || wr_at(OFS_VOLATILE_CMD))) begin
            vol_ff[slot_sel_ff] <= cur_set;
        end
    end

    // lookup table storage, identity after reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < LUT_DEPTH; i++) begin
                lut_ff[i] <= i[PIX_W-1:0];
            end
        end else if (wr_at(OFS_TABLE_OUTPUT)) begin
            lut_ff[lut_idx_ff] <= reg_wdata[PIX_W-1:0];
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst || !reg_rd) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            case (reg_addr)
                OFS_AMPLIFICATION: rdata_ff <= 32'(amp_ff);
                OFS_PEDESTAL_OFFSET: rdata_ff <= 32'($signed(ped_ff));
                OFS_COLOR_SELECT: rdata_ff <= 32'(sel_ff);
                OFS_COLOR_MULT: begin
                    case (sel_ff)
                        CH_RED: rdata_ff <= 32'(red_ff);
                        CH_BLUE: rdata_ff <= 32'(blue_ff);
                        default: rdata_ff <= 32'h0000_0000;
                    endcase
                end
                OFS_AUTO_WB: rdata_ff <= 32'(state_ff == ST_AWB);
                OFS_TABLE_ENABLE: rdata_ff <= 32'(lut_en_ff);
                OFS_TABLE_INPUT: rdata_ff <= 32'(lut_idx_ff);
                OFS_TABLE_OUTPUT: rdata_ff <= 32'(lut_ff[lut_idx_ff]);
                OFS_SLOT_SELECT: rdata_ff <= 32'(slot_sel_ff);
                OFS_POWER_UP_SLOT: rdata_ff <= 32'(pwr_slot_ff);
                OFS_PIXEL_ENCODING: rdata_ff <= 32'(enc_ff);
                OFS_OTHER_PARAMS: rdata_ff <= other_ff;
                OFS_SEQUENCE_ENABLE: rdata_ff <= 32'(seq_en_ff);
                OFS_STATUS: rdata_ff <= 32'({gain_busy, state_ff == ST_AWB, COLOR_MODEL});
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // relaunch the factor converter whenever the gain code moves
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            launched_ff <= AMP_RESET;
        end else begin
            launched_ff <= amp_ff;
        end
    end

    gain_factor_calc u_gain (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(amp_ff != launched_ff),
        .code(amp_ff),
        .busy(gain_busy),
        .factor(factor)
    );

    // stage arithmetic
    logic [33:0] gain_prod;
    logic signed [14:0] ped_scaled;
    logic signed [14:0] ped_sum;
    logic [RATIO_W-1:0] wb_ratio;
    logic [23:0] wb_prod;
    logic wb_on;

    assign gain_prod = pix_in.value * factor;
    assign ped_scaled = 15'($signed(ped_ff)) <<< PED_SHIFT;
    assign ped_sum = $signed({3'b000, s1_ff.value}) + ped_scaled;
    assign wb_on = color_ok && (s2_ff.phase != PH_GREEN);
    assign wb_ratio = (s2_ff.phase == PH_RED) ? red_ff : blue_ff;
    assign wb_prod = s2_ff.value * wb_ratio;

    // gain, pedestal, balance, then table, each clamped to 12 bits
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            out_ff <= '0;
        end else begin
            s1_ff <= pix_in;
            s1_ff.value <= clamp_pix(gain_prod >> FACT_FRAC);
            s2_ff <= s1_ff;
            s2_ff.value <= clamp_signed(ped_sum);
            s3_ff <= s2_ff;
            if (wb_on) begin
                s3_ff.value <= clamp_pix({10'h000, wb_prod} >> RATIO_FRAC);
            end
            out_ff <= s3_ff;
            if (lut_en_ff) begin
                out_ff.value <= lut_ff[s3_ff.value];
            end
        end
    end

    assign reg_rdata = rdata_ff;
    assign pix_out = out_ff;
    assign awb_start = awb_start_ff;
endmodule : pixel_gain_lut_settings_store
`default_nettype wire

// ---- bench/pixel_gain_lut_settings_store_assertions.sv ----
// bound checker for the register port, balance request and pixel stream
`timescale 1ns/1ps
`default_nettype none
module pixel_gain_lut_settings_store_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic nv_init,
    input wire logic [pixel_gain_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire pixel_gain_pkg::pixel_s pix_in,
    input wire pixel_gain_pkg::pixel_s pix_out,
    input wire logic awb_start,
    input wire pixel_gain_pkg::awb_result_s awb_res
);
    import pixel_gain_pkg::*;
    // one clock domain, checks off while reset is high
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // stream framing leaves four stages later untouched
    a_pix_ctrl_pass: assert property ($past(pix_in.valid, 4) |-> pix_out.valid &&
        pix_out.phase == $past(pix_in.phase, 4)) else $error("pixel framing not delayed by four");
    a_awb_start_cause: assert property (awb_start |->
        $past(reg_wr && reg_addr == OFS_AUTO_WB && reg_wdata[0])) else $error("balance start without request");
    a_awb_one_pulse: assert property (awb_start |=> !awb_start) else $error("balance start too long");
    a_amp_read_max: assert property (reg_rd && reg_addr == OFS_AMPLIFICATION |=>
        reg_rdata <= 32'h168) else $error("gain code above limit");
    a_sel_read_range: assert property (reg_rd && reg_addr == OFS_COLOR_SELECT |=>
        reg_rdata <= 32'h2) else $error("channel select out of range");
    a_mult_read_max: assert property (reg_rd && reg_addr == OFS_COLOR_MULT |=>
        reg_rdata <= 32'h800) else $error("multiplier above eight");
    a_slot_read_range: assert property (reg_rd && reg_addr == OFS_SLOT_SELECT |=>
        reg_rdata <= 32'hF) else $error("slot number out of range");
    a_table_out_width: assert property (reg_rd && reg_addr == OFS_TABLE_OUTPUT |=>
        reg_rdata[31:12] == 20'h0) else $error("table entry wider than 12 bits");
endmodule : pixel_gain_lut_settings_store_checker
bind pixel_gain_lut_settings_store pixel_gain_lut_settings_store_checker i_chk (.sys_clk, .rst,
    .nv_init, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pix_in, .pix_out, .awb_start,
    .awb_res);
`default_nettype wire

// ---- bench/sensor_stream_model.sv ----
// readout source and balance engine beside the pixel stage
`timescale 1ns/1ps
`default_nettype none
module sensor_stream_model #(
    parameter int DLY = 6
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [11:0] level,
    input wire logic [1:0] phase,
    input wire logic awb_start,
    output var pixel_gain_pkg::pixel_s pix,
    output var pixel_gain_pkg::awb_result_s res
);
    import pixel_gain_pkg::*;
    int cnt;
    // one pixel every clock, no gaps
    always_ff @(posedge sys_clk) begin
        pix <= rst ? pixel_s'('0) : pixel_s'{valid: 1'b1, sof: 1'b0, phase: phase, value: level};
    end
    // one pass per request; gains wander when no result stands
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt <= 0;
            res <= '0;
        end else begin
            cnt <= awb_start ? DLY : (cnt > 0 ? cnt - 1 : 0);
            res <= (cnt == 1) ? awb_result_s'{done: 1'b1, ok: 1'b1, red: 12'h180, blue: 12'h300}
                : awb_result_s'{done: 1'b0, ok: 1'b0, red: ~res.red, blue: ~res.blue};
        end
    end
endmodule : sensor_stream_model
`default_nettype wire

// ---- bench/pixel_gain_lut_settings_store_bench.sv ----
// self-checking bench for the pixel stage and settings store
`timescale 1ns/1ps
`default_nettype none
module pixel_gain_lut_settings_store_bench;
    import pixel_gain_pkg::*;
    logic sys_clk, rst, nv_init, reg_wr, reg_rd, awb_start;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [11:0] level;
    logic [1:0] phase;
    pixel_s pix_in, pix_out;
    awb_result_s awb_res;
    int err_count, checked, cycles;
    pixel_gain_lut_settings_store i_dut (.sys_clk, .rst, .nv_init, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .pix_in, .pix_out, .awb_start, .awb_res);
    sensor_stream_model i_src (.sys_clk, .rst, .level, .phase, .awb_start, .pix(pix_in),
        .res(awb_res));
    // 8 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    // steady input level, then look at the settled output
    task automatic px(input logic [11:0] v, input logic [1:0] p, input logic [11:0] exp);
        @(posedge sys_clk);
        level <= v;
        phase <= p;
        repeat (16) @(posedge sys_clk);
        #1 chk({20'h0, pix_out.value}, {20'h0, exp});
    endtask : px
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    // main sequence
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, level, phase} = '0;
        rst = 1'b1;
        nv_init = 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        nv_init <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(OFS_AMPLIFICATION, 32'h0);
        rd(OFS_PEDESTAL_OFFSET, 32'h0);
        rd(OFS_COLOR_SELECT, 32'h0);
        rd(OFS_COLOR_MULT, 32'h0);
        rd(OFS_AUTO_WB, 32'h0);
        rd(OFS_STATUS, 32'h1);
        px(12'h123, PH_GREEN, 12'h123);
        $display("reset values done");
        wr(OFS_AMPLIFICATION, 32'h190);
        rd(OFS_AMPLIFICATION, 32'h168);
        px(12'h190, PH_GREEN, 12'hFFF);
        wr(OFS_AMPLIFICATION, 32'h0);
        wr(OFS_PEDESTAL_OFFSET, 32'h100);
        px(12'h7D0, PH_GREEN, 12'hBD0);
        wr(OFS_PEDESTAL_OFFSET, 32'hFFFF_FED4);
        px(12'h1F4, PH_GREEN, 12'h0);
        wr(OFS_PEDESTAL_OFFSET, 32'h0);
        $display("gain and pedestal done");
        wr(OFS_COLOR_SELECT, 32'h1);
        wr(OFS_COLOR_MULT, 32'h200);
        rd(OFS_COLOR_MULT, 32'h100);
        wr(OFS_PIXEL_ENCODING, 32'h1);
        wr(OFS_COLOR_MULT, 32'h200);
        rd(OFS_COLOR_MULT, 32'h200);
        px(12'h3E8, PH_RED, 12'h7D0);
        wr(OFS_COLOR_SELECT, 32'h3);
        rd(OFS_COLOR_SELECT, 32'h1);
        wr(OFS_COLOR_SELECT, 32'h2);
        rd(OFS_COLOR_MULT, 32'h100);
        wr(OFS_COLOR_MULT, 32'h900);
        rd(OFS_COLOR_MULT, 32'h800);
        wr(OFS_AUTO_WB, 32'h1);
        rd(OFS_AUTO_WB, 32'h1);
        repeat (12) @(posedge sys_clk);
        rd(OFS_COLOR_MULT, 32'h300);
        rd(OFS_AUTO_WB, 32'h0);
        $display("color balance done");
        wr(OFS_TABLE_INPUT, 32'h5);
        wr(OFS_TABLE_OUTPUT, 32'hABC);
        rd(OFS_TABLE_OUTPUT, 32'hABC);
        px(12'h5, PH_GREEN, 12'h5);
        wr(OFS_TABLE_ENABLE, 32'h1);
        px(12'h5, PH_GREEN, 12'hABC);
        wr(OFS_TABLE_ENABLE, 32'h0);
        $display("table done");
        wr(OFS_AMPLIFICATION, 32'h32);
        wr(OFS_SLOT_SELECT, 32'h3);
        wr(OFS_SEQUENCE_ENABLE, 32'h1);
        wr(OFS_OTHER_PARAMS, 32'h5A5A_0001);
        wr(OFS_PERSIST_CMD, 32'h0);
        wr(OFS_AMPLIFICATION, 32'h10);
        wr(OFS_PIXEL_ENCODING, 32'h0);
        wr(OFS_OTHER_PARAMS, 32'h0);
        wr(OFS_RESTORE_CMD, 32'h0);
        rd(OFS_AMPLIFICATION, 32'h32);
        rd(OFS_PIXEL_ENCODING, 32'h1);
        rd(OFS_OTHER_PARAMS, 32'h5A5A_0001);
        wr(OFS_SLOT_SELECT, 32'h4);
        wr(OFS_AMPLIFICATION, 32'h20);
        wr(OFS_VOLATILE_CMD, 32'h0);
        wr(OFS_AMPLIFICATION, 32'h0);
        wr(OFS_RESTORE_CMD, 32'h0);
        rd(OFS_AMPLIFICATION, 32'h20);
        wr(OFS_SLOT_SELECT, 32'h10);
        rd(OFS_SLOT_SELECT, 32'h4);
        wr(OFS_SLOT_SELECT, 32'h0);
        wr(OFS_PERSIST_CMD, 32'h0);
        wr(OFS_RESTORE_CMD, 32'h0);
        rd(OFS_AMPLIFICATION, 32'h0);
        rd(OFS_SEQUENCE_ENABLE, 32'h0);
        wr(OFS_POWER_UP_SLOT, 32'h3);
        rst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(OFS_AMPLIFICATION, 32'h32);
        rd(OFS_SEQUENCE_ENABLE, 32'h1);
        wr(OFS_SLOT_SELECT, 32'h4);
        wr(OFS_RESTORE_CMD, 32'h0);
        rd(OFS_AMPLIFICATION, 32'h0);
        $display("settings slots done");
        test_done();
    end
endmodule : pixel_gain_lut_settings_store_bench
`default_nettype wire
